// ===== hdl/alt_intf_cfg.svh
`ifndef ALT_INTF_CFG_SVH
`define ALT_INTF_CFG_SVH
// Register addresses
`define ADDR_ALT_INTF_WRITE 6'h07
`define ADDR_ALT_INTF_SET   6'h08
`define ADDR_ALT_INTF_CLEAR 6'h09
// Reset value
`define ALT_INTF_RESET      8'h00
// Read data returned for an unmapped read address
`define ALT_INTF_RD_NONE    8'h00
// Byte with no bit set, used when checking cleared bits
`define ALT_INTF_NO_BITS    8'h00
// Pin guard levels: both pulls on during reset, none when switched off
`define PIN_GUARD_RESET     2'h3
`define PIN_GUARD_NONE      2'h0
`endif

// ===== hdl/alt_intf_pkg.sv
package alt_intf_pkg;
  // Field layout of the alternative interface control register
  typedef struct packed {
    logic pinGuardOff;           // bit 7
    logic indicatorUnqualified;  // bit 6
    logic indicatorInvert;       // bit 5
    logic reserved4;             // bit 4
    logic serialClockKeepOnN;    // bit 3
    logic reserved2;             // bit 2
    logic threeWireSerialMode;   // bit 1
    logic sixWireSerialMode;     // bit 0
  } alt_ctrl_s;

  // Register access request from the ULPI register protocol engine
  typedef struct packed {
    logic       wrValid;
    logic [5:0] addr;
    logic [7:0] wrData;
  } reg_req_s;

  // Pin protection controls
  typedef struct packed {
    logic stpPullUp;
    logic dataPullDown;
  } pin_guard_s;
endpackage

// ===== hdl/ulpi_alt_interface_control.sv
`timescale 1ns/1ns
`include "alt_intf_cfg.svh"

//------------------------------------------------------------
// Alternative interface control register
//------------------------------------------------------------
// Function
// - Read 07h-09h; write, set, clear addresses
// - Guard on: detect link releasing STP
// - Guard on: STP pull-up, DATA pull-downs when STP is high unexpectedly
// - Guard off removes all weak pulls
// - Invert bit complements overcurrent input
// - Qualify indicator with supply comparator unless unqualified
// - Clock kept powered in serial only if set
// - Clock bit only valid serial and powered
// - Bit 1 selects three-wire serial
// - Bit 0 selects six-wire serial
// - Device clears mode bit on serial exit
module ulpi_alt_interface_control (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire alt_intf_pkg::reg_req_s regReq,
  input  wire logic [5:0]             rdAddr,
  input  wire logic                   stpDriven,
  input  wire logic                   stpLevel,
  input  wire logic                   stpExpected,
  input  wire logic                   phyLowPowerN,
  input  wire logic                   serialExit,
  input  wire logic                   overcurrentIn,
  input  wire logic                   hostSupplyValidComparator,
  output logic [7:0]                  rdData,
  output logic                        rdHit,
  output alt_intf_pkg::alt_ctrl_s     ctrl,
  output alt_intf_pkg::pin_guard_s    pinGuard,
  output logic                        stpReleased,
  output logic                        supplyIndicator,
  output logic                        serialClockOn,
  output logic                        threeWireActive,
  output logic                        sixWireActive
);

  alt_intf_pkg::alt_ctrl_s  next_ctrl;
  alt_intf_pkg::pin_guard_s next_pinGuard;
  logic [7:0]               next_rdData;
  logic                     next_rdHit;
  logic                     next_stpReleased;
  logic                     next_supplyIndicator;
  logic                     next_serialClockOn;
  logic                     complement;
  logic                     serialOn;

  //------------------------------------------------------------
  // Register update
  //------------------------------------------------------------
  // Write, set and clear, then hardware clear on serial exit
  always_comb begin
    next_ctrl = ctrl;
    if (regReq.wrValid) begin
      unique case (regReq.addr)
        `ADDR_ALT_INTF_WRITE: next_ctrl = regReq.wrData;
        `ADDR_ALT_INTF_SET:   next_ctrl = ctrl | regReq.wrData;
        `ADDR_ALT_INTF_CLEAR: next_ctrl = ctrl & ~regReq.wrData;
        default: ;
      endcase
    end
    if (serialExit) begin
      next_ctrl.threeWireSerialMode = 1'b0;
      next_ctrl.sixWireSerialMode   = 1'b0;
    end
  end

  // Register byte, all zero after reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl <= `ALT_INTF_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  //------------------------------------------------------------
  // Register access checks
  //------------------------------------------------------------
  // Plain write replaces the whole byte
  a_plain_write: assert property (@(posedge clk) disable iff (reset)
    regReq.wrValid && regReq.addr == `ADDR_ALT_INTF_WRITE && !serialExit |=> ctrl == $past(regReq.wrData))
    else $error("plain write wrong");
  // Set address merges the written ones in
  a_set_ors_byte: assert property (@(posedge clk) disable iff (reset)
    regReq.wrValid && regReq.addr == `ADDR_ALT_INTF_SET && !serialExit
    |=> ctrl == ($past(ctrl) | $past(regReq.wrData)))
    else $error("set write wrong");
  // Clear address drops every bit written as one
  a_clear_bits: assert property (@(posedge clk) disable iff (reset)
    regReq.wrValid && regReq.addr == `ADDR_ALT_INTF_CLEAR |=> (ctrl & $past(regReq.wrData)) == `ALT_INTF_NO_BITS)
    else $error("clear write wrong");
  // Clear address leaves the bits written as zero alone
  a_clear_keeps: assert property (@(posedge clk) disable iff (reset)
    regReq.wrValid && regReq.addr == `ADDR_ALT_INTF_CLEAR && !serialExit
    |=> ctrl == ($past(ctrl) & ~$past(regReq.wrData)))
    else $error("clear write touched other bits");
  // Any other address, or no write at all, leaves the byte alone
  a_unmapped_write: assert property (@(posedge clk) disable iff (reset)
    !(regReq.wrValid && regReq.addr inside {`ADDR_ALT_INTF_WRITE, `ADDR_ALT_INTF_SET, `ADDR_ALT_INTF_CLEAR})
    && !serialExit |=> $stable(ctrl))
    else $error("byte changed without a write");
  // Leaving serial mode clears the three-wire bit and both active flags
  a_serial_exit: assert property (@(posedge clk) disable iff (reset)
    serialExit |=> !threeWireActive && !sixWireActive && !ctrl.threeWireSerialMode)
    else $error("serial bit not cleared");
  // Leaving serial mode clears the six-wire bit as well
  a_six_wire_exit: assert property (@(posedge clk) disable iff (reset)
    serialExit |=> !ctrl.sixWireSerialMode)
    else $error("six-wire bit not cleared");

  //------------------------------------------------------------
  // Derived controls and readback
  //------------------------------------------------------------
  // Any serial mode active, and the overcurrent input after the invert bit
  assign serialOn   = ctrl.threeWireSerialMode | ctrl.sixWireSerialMode;
  assign complement = overcurrentIn ^ ctrl.indicatorInvert;

  // Next values of the status outputs other than the two active mode flags
  always_comb begin
    next_rdHit  = (rdAddr == `ADDR_ALT_INTF_WRITE) || (rdAddr == `ADDR_ALT_INTF_SET) ||
                  (rdAddr == `ADDR_ALT_INTF_CLEAR);
    next_rdData = next_rdHit ? ctrl : `ALT_INTF_RD_NONE;
    next_stpReleased = ~ctrl.pinGuardOff & ~stpDriven;
    next_pinGuard.stpPullUp    = ~ctrl.pinGuardOff;
    next_pinGuard.dataPullDown = ~ctrl.pinGuardOff & stpLevel & ~stpExpected;
    next_supplyIndicator = ctrl.indicatorUnqualified ? complement :
                           (complement & hostSupplyValidComparator);
    // Bit only honoured in serial mode with the PHY powered
    next_serialClockOn = serialOn & (phyLowPowerN ? ctrl.serialClockKeepOnN : 1'b0);
  end

  // Output flops; both weak pulls stay on while in reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdData          <= `ALT_INTF_RD_NONE;
      rdHit           <= 1'b0;
      stpReleased     <= 1'b0;
      pinGuard        <= `PIN_GUARD_RESET;
      supplyIndicator <= 1'b0;
      serialClockOn   <= 1'b0;
      threeWireActive <= 1'b0;
      sixWireActive   <= 1'b0;
    end else begin
      rdData          <= next_rdData;
      rdHit           <= next_rdHit;
      stpReleased     <= next_stpReleased;
      pinGuard        <= next_pinGuard;
      supplyIndicator <= next_supplyIndicator;
      serialClockOn   <= next_serialClockOn;
      threeWireActive <= next_ctrl.threeWireSerialMode;
      sixWireActive   <= next_ctrl.sixWireSerialMode;
    end
  end

  //------------------------------------------------------------
  // Read-back checks
  //------------------------------------------------------------
  // Clear address reads back the stored byte
  a_read_back: assert property (@(posedge clk) disable iff (reset)
    rdAddr == `ADDR_ALT_INTF_CLEAR && !regReq.wrValid && !serialExit |=> rdHit && rdData == ctrl)
    else $error("readback wrong");
  // Unmapped read address gives no hit and empty data
  a_read_miss: assert property (@(posedge clk) disable iff (reset)
    !(rdAddr inside {`ADDR_ALT_INTF_WRITE, `ADDR_ALT_INTF_SET, `ADDR_ALT_INTF_CLEAR})
    |=> !rdHit && rdData == `ALT_INTF_RD_NONE)
    else $error("unmapped read not empty");

  //------------------------------------------------------------
  // Pin guard checks
  //------------------------------------------------------------
  // Guard switched off removes every weak pull
  a_guard_off: assert property (@(posedge clk) disable iff (reset)
    ctrl.pinGuardOff |=> pinGuard == `PIN_GUARD_NONE && !stpReleased)
    else $error("guard not removed");
  // Unexpected STP high brings in the data pull-downs
  a_guard_pull: assert property (@(posedge clk) disable iff (reset)
    !ctrl.pinGuardOff && stpLevel && !stpExpected |=> pinGuard.dataPullDown && pinGuard.stpPullUp)
    else $error("guard pulls missing");
  // Otherwise only the STP pull-up stays on
  a_guard_quiet: assert property (@(posedge clk) disable iff (reset)
    !ctrl.pinGuardOff && !(stpLevel && !stpExpected) |=> pinGuard.stpPullUp && !pinGuard.dataPullDown)
    else $error("data pulled down while STP expected");
  // Released STP is flagged while the guard is on
  a_stp_release: assert property (@(posedge clk) disable iff (reset)
    !ctrl.pinGuardOff && !stpDriven |=> stpReleased)
    else $error("release not seen");

  //------------------------------------------------------------
  // Indicator checks
  //------------------------------------------------------------
  // Qualified indicator stays low without a valid supply
  a_indicator: assert property (@(posedge clk) disable iff (reset)
    !ctrl.indicatorUnqualified && !hostSupplyValidComparator |=> !supplyIndicator)
    else $error("indicator not qualified");
  // Invert bit complements the overcurrent input
  a_invert: assert property (@(posedge clk) disable iff (reset)
    ctrl.indicatorUnqualified && ctrl.indicatorInvert |=> supplyIndicator == !$past(overcurrentIn))
    else $error("indicator not inverted");
  // Without the invert bit the input passes straight through
  a_pass_through: assert property (@(posedge clk) disable iff (reset)
    ctrl.indicatorUnqualified && !ctrl.indicatorInvert |=> supplyIndicator == $past(overcurrentIn))
    else $error("indicator inverted without the bit");

  //------------------------------------------------------------
  // Serial clock and mode checks
  //------------------------------------------------------------
  // Clock bit ignored outside serial mode or in low power
  a_clock_keep: assert property (@(posedge clk) disable iff (reset)
    !phyLowPowerN || !serialOn |=> !serialClockOn)
    else $error("clock bit not ignored");
  // Clock bit honoured in serial mode with the PHY powered
  a_clock_on: assert property (@(posedge clk) disable iff (reset)
    serialOn && phyLowPowerN && ctrl.serialClockKeepOnN |=> serialClockOn)
    else $error("serial clock not kept on");
  // Active mode flags follow their register bits
  a_mode_copy: assert property (@(posedge clk) disable iff (reset)
    threeWireActive == ctrl.threeWireSerialMode && sixWireActive == ctrl.sixWireSerialMode)
    else $error("active mode differs from its bit");

  //------------------------------------------------------------
  // Coverage of the main scenarios
  //------------------------------------------------------------
  c_three_wire: cover property (@(posedge clk) disable iff (reset) threeWireActive ##1 serialExit);
  c_six_wire: cover property (@(posedge clk) disable iff (reset) sixWireActive && serialClockOn);
  c_guard_pull: cover property (@(posedge clk) disable iff (reset) pinGuard.dataPullDown);
  c_guard_off: cover property (@(posedge clk) disable iff (reset) ctrl.pinGuardOff && !stpDriven);
  c_read_hit: cover property (@(posedge clk) disable iff (reset) rdHit && rdData != `ALT_INTF_RD_NONE);
endmodule

// ===== verif/ulpi_link_model.sv
`timescale 1ns/1ns
//--------------------------------
// Link side: register requests and STP pin
//--------------------------------
module ulpi_link_model (
  input  wire logic                     clk,
  input  wire alt_intf_pkg::pin_guard_s pinGuard,
  output alt_intf_pkg::reg_req_s        regReq,
  output logic [5:0]                    rdAddr,
  output logic                          stpDriven,
  output logic                          stpLevel
);
  // Idle levels at time zero
  initial begin
    regReq = '0;
    rdAddr = 6'h00;
    stpDriven = 1'b1;
    stpLevel = 1'b0;
  end
  // One cycle of link activity, called just after a rising edge
  task automatic drive(input logic w, input logic [5:0] a, input logic [7:0] d,
                       input logic [5:0] ra, input logic drv, input logic lvl);
    regReq <= '{w, a, w ? d : ~d}; // Idle data is scrambled, not held
    rdAddr <= ra;
    stpDriven <= drv;
    stpLevel <= drv ? lvl : (pinGuard.stpPullUp | ~stpLevel); // Released STP: pull-up or toggling
  endtask
endmodule

// ===== verif/tb_ulpi_alt_interface_control.sv
`timescale 1ns/1ns
//--------------------------------
// Random register and pin checks
//--------------------------------
module tb_ulpi_alt_interface_control;
  logic clk = 1'b0, reset = 1'b1, stpExpected = 1'b0, phyLowPowerN = 1'b1, serialExit = 1'b0;
  logic overcurrentIn = 1'b0, hostSupplyValidComparator = 1'b0, rdHit, stpReleased, supplyIndicator;
  logic serialClockOn, threeWireActive, sixWireActive, stpDriven, stpLevel;
  logic [7:0]               rdData;
  logic [5:0]               rdAddr;
  alt_intf_pkg::reg_req_s   regReq;
  alt_intf_pkg::alt_ctrl_s  ctrl;
  alt_intf_pkg::pin_guard_s pinGuard;
  int                       fails = 0, checks_done = 0;
  logic [31:0]              seed = 32'h59A9;
  logic [7:0]               expQ[$];
  // Free-running clock
  always #4 clk = ~clk;
  ulpi_link_model link (.clk(clk), .pinGuard(pinGuard), .regReq(regReq), .rdAddr(rdAddr),
    .stpDriven(stpDriven), .stpLevel(stpLevel));
  ulpi_alt_interface_control uut (.clk(clk), .reset(reset), .regReq(regReq), .rdAddr(rdAddr),
    .stpDriven(stpDriven), .stpLevel(stpLevel), .stpExpected(stpExpected), .phyLowPowerN(phyLowPowerN),
    .serialExit(serialExit), .overcurrentIn(overcurrentIn), .hostSupplyValidComparator(hostSupplyValidComparator),
    .rdData(rdData), .rdHit(rdHit), .ctrl(ctrl), .pinGuard(pinGuard), .stpReleased(stpReleased),
    .supplyIndicator(supplyIndicator), .serialClockOn(serialClockOn), .threeWireActive(threeWireActive),
    .sixWireActive(sixWireActive));
  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Byte compare
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Flag compare
  task automatic cmp_flag(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  // Verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Reset, then write/set/clear or unmapped-address (0Ah) write cycles each followed by a read and pin check
  initial begin
    logic [31:0] r;
    logic [7:0] m, d;
    logic [5:0] a, ra;
    logic lvl, sx, cmpl;
    m = 8'h00;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    cmp(ctrl, 8'h00, "reset value");
    $display("reset test done");
    for (int i = 0; i < 400; i++) begin
      r = rnd();
      a = r[1:0] == 2'd3 ? 6'h0A : 6'h07 + {4'h0, r[1:0]};
      ra = 6'h06 + {4'h0, r[31:30]};
      d = r[15:8];
      if (d[1] || (a == 6'h08 && m[1])) d[0] = 1'b0;
      if (a == 6'h08 && m[0]) d[1] = 1'b0;
      sx = r[20:17] == 4'h0;
      @(posedge clk);
      link.drive(1'b1, a, d, ra, r[27], r[28]);
      serialExit <= sx;
      if (a == 6'h07) m = d;
      if (a == 6'h08) m = m | d;
      if (a == 6'h09) m = m & ~d;
      if (sx) m = m & 8'hFC;
      expQ.push_back(m);
      @(posedge clk);
      link.drive(1'b0, 6'h00, d, ra, r[27], r[28]);
      {serialExit, overcurrentIn, hostSupplyValidComparator, phyLowPowerN, stpExpected} <= {1'b0, r[6:3]};
      @(negedge clk);
      lvl = stpLevel;
      cmpl = r[6] ^ m[5];
      @(posedge clk);
      #1;
      cmp(ctrl, expQ.pop_front(), "ctrl");
      cmp(rdData, (ra != 6'h06) ? m : 8'h00, "read data");
      cmp_flag(pinGuard.stpPullUp, ~m[7], "STP pull-up");
      cmp_flag(pinGuard.dataPullDown, ~m[7] & lvl & ~r[3], "data pull-down");
      cmp_flag(stpReleased, ~m[7] & ~r[27], "STP release");
      cmp_flag(supplyIndicator, m[6] ? cmpl : cmpl & r[5], "indicator");
      cmp_flag(serialClockOn, (m[1] | m[0]) & r[4] & m[3], "serial clock");
      cmp_flag(threeWireActive, m[1], "three-wire");
      cmp_flag(sixWireActive, m[0], "six-wire");
      cmp_flag(rdHit, ra != 6'h06, "read hit");
    end
    $display("random register and pin test done");
    summarize();
  end
endmodule
